// ==== rtl/vpm_regs.sv ====
// vpm_regs: partition map registers 2 and 3 with access checks and lookup
`timescale 1ns/100ps
// How it works
// - register 2 decoded at 3/4/10/6/2
// - any access from EL0 is undefined
// - EL1 nested-memory read redirects to 0x950 (0x958 for register 3)
// - EL1 nested-memory write stores at 0x950 (0x958 for register 3)
// - EL3 trap unless halted with secure debug off
// - EL1 nested only: EL3 path, else EL2 trap
// - other EL1 accesses are undefined
// - EL2 uses EL3 path or accesses register
// - EL3 reads full register without checks
// - register 3 maps virtual ids 12 to 15
// - highest index field is at most seven
// - index zero means only register 0 exists
// - per-level enables gate EL1 and EL0 translation
// - entry n used only with valid bit n
// - register 3 needs feature, control, index above 2
// - no mapping effect without EL2 enabled
// - register 3 holds four 16-bit entries
// - entries have no defined reset value
module vpm_regs
	import vpm_pkg::*;
#(
	parameter int PID_W = 16, // width of one physical id entry
	parameter int REG_W = 64 // width of a mapping register
) (
	input logic ref_clk,
	input logic rst,
	// access request from the core, one-cycle pulse
	input logic acc_req,
	input logic acc_write,
	input logic [1:0] acc_op0,
	input logic [2:0] acc_op1,
	input logic [3:0] acc_crn,
	input logic [3:0] acc_crm,
	input logic [2:0] acc_op2,
	input logic [REG_W-1:0] acc_wdata,
	// processor state at the time of the request
	input logic [1:0] cur_el,
	input logic el2_enabled,
	input logic nested_virt_bit,
	input logic nested_virt_memory_bit,
	input logic have_el3,
	input logic lower_level_trap_bit,
	input logic core_halted,
	input logic secure_debug_disabled,
	// configuration straps of the feature
	input logic partitioning_feature_present,
	input logic hypervisor_control_present,
	input logic [2:0] highest_map_register_index,
	// translation controls
	input logic el1_map_enable,
	input logic el0_map_enable,
	input logic [15:0] map_entry_valid_bits,
	// lookup of a virtual id
	input logic lookup_req,
	input logic [3:0] lookup_vid,
	input logic lookup_from_el1,
	// access response
	output logic resp_valid_q,
	output logic resp_undef_q,
	output logic resp_trap_q,
	output logic resp_trap_el3_q,
	output logic [5:0] resp_syndrome_q,
	output logic resp_redirect_q,
	output logic resp_redirect_write_q,
	output logic [11:0] resp_slot_offset_q,
	output logic [REG_W-1:0] resp_data_q,
	// lookup response
	output logic lookup_valid_q,
	output logic lookup_use_q,
	output logic [PID_W-1:0] lookup_phys_q
);
	// ==========================================================
	// elaboration check
	if (PID_W * VPM_ENTRIES != REG_W) begin : g_bad_width
		$error("vpm_regs: four entries must fill the register exactly");
	end

	// ==========================================================
	// storage: index 0 is register 2, index 1 is register 3
	logic [REG_W-1:0] map_q [2]; // no reset, entries are unknown after reset
	logic [REG_W-1:0] map_d [2];

	// ==========================================================
	// decode
	wire enc_common = (acc_op0 == VPM_OP0) && (acc_op1 == VPM_OP1)
		&& (acc_crn == VPM_CRN) && (acc_crm == VPM_CRM);
	wire hit_map2 = enc_common && (acc_op2 == VPM_OP2_MAP2);
	wire hit_map3 = enc_common && (acc_op2 == VPM_OP2_MAP3);
	wire acc_hit = acc_req && (hit_map2 || hit_map3);
	// the 3-bit field cannot exceed seven; zero leaves both absent
	wire base_present = partitioning_feature_present && hypervisor_control_present;
	wire map2_present = base_present && (highest_map_register_index > VPM_MIN_IDX_MAP2);
	wire map3_present = base_present
		&& (highest_map_register_index > VPM_MIN_IDX_MAP3);
	wire sel_present = hit_map3 ? map3_present : map2_present;
	wire sel_idx = hit_map3;
	// the lower-level trap only counts where EL3 exists
	wire el3_trap_on = have_el3 && lower_level_trap_bit;
	// halted with secure debug disabled turns an EL3 trap into undefined
	wire el3_blocked = core_halted && secure_debug_disabled;
	wire nv_mem = el2_enabled && nested_virt_bit && nested_virt_memory_bit;
	wire nv_only = el2_enabled && nested_virt_bit;

	// ==========================================================
	// access check, evaluated in priority order
	vpm_outcome_e outcome;
	vpm_outcome_e el3_path;
	// EL3 trap path shared by EL1 and EL2
	assign el3_path = el3_blocked ? VPM_UNDEF : VPM_TRAP_EL3;

	always_comb begin
		outcome = VPM_UNDEF;
		if (!sel_present) begin
			// absent register: undefined
			outcome = VPM_UNDEF;
		end else begin
			unique case (cur_el)
				VPM_EL0: begin
					outcome = VPM_UNDEF;
				end
				VPM_EL1: begin
					if (nv_mem) begin
						outcome = VPM_REDIRECT;
					end else if (nv_only) begin
						outcome = el3_trap_on ? el3_path : VPM_TRAP_EL2;
					end else begin
						outcome = VPM_UNDEF;
					end
				end
				VPM_EL2: begin
					outcome = el3_trap_on ? el3_path : VPM_ACCESS;
				end
				VPM_EL3: begin
					outcome = VPM_ACCESS; // no check at the top level
				end
			endcase
		end
	end

	// ==========================================================
	// register update: writes follow the same
	wire do_write = acc_hit && acc_write && (outcome == VPM_ACCESS);
	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : g_map
		// the loop index is cut on purpose to the one-bit register select
		assign map_d[gi] = (do_write && (sel_idx == 1'(gi))) ? acc_wdata : map_q[gi];
		// plain data flop with no reset, the register keeps its last value
		always_ff @(posedge ref_clk) begin
			map_q[gi] <= map_d[gi];
		end
	end

	// ==========================================================
	// response, one cycle after the request
	wire resp_is_trap = (outcome == VPM_TRAP_EL2) || (outcome == VPM_TRAP_EL3);
	wire [11:0] slot_sel = hit_map3 ? VPM_SLOT_MAP3 : VPM_SLOT_MAP2;
	// read data only for a direct read; redirected reads come from memory
	wire [REG_W-1:0] rdata_sel = (outcome == VPM_ACCESS && !acc_write)
		? map_q[sel_idx] : VPM_DATA_RST;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			resp_valid_q <= 1'b0;
			resp_undef_q <= 1'b0;
			resp_trap_q <= 1'b0;
			resp_trap_el3_q <= 1'b0;
			resp_syndrome_q <= 6'h0;
			resp_redirect_q <= 1'b0;
			resp_redirect_write_q <= 1'b0;
			resp_slot_offset_q <= 12'h0;
			resp_data_q <= VPM_DATA_RST;
		end else begin
			resp_valid_q <= acc_hit;
			resp_undef_q <= acc_hit && (outcome == VPM_UNDEF);
			resp_trap_q <= acc_hit && resp_is_trap;
			resp_trap_el3_q <= acc_hit && (outcome == VPM_TRAP_EL3);
			resp_syndrome_q <= (acc_hit && resp_is_trap) ? VPM_EC_SYSREG : 6'h0;
			resp_redirect_q <= acc_hit && (outcome == VPM_REDIRECT);
			resp_redirect_write_q <= acc_hit && (outcome == VPM_REDIRECT) && acc_write;
			resp_slot_offset_q <= (acc_hit && outcome == VPM_REDIRECT) ? slot_sel : 12'h0;
			// a redirected write hands the source value on to the memory slot
			if (acc_hit && outcome == VPM_REDIRECT && acc_write) begin
				resp_data_q <= acc_wdata;
			end else begin
				resp_data_q <= acc_hit ? rdata_sel : VPM_DATA_RST;
			end
		end
	end

	// ==========================================================
	// lookup: only ids 8 to 15 live here, others are never used
	wire lk_reg = lookup_vid[2]; // 0 selects register 2, 1 register 3
	wire [1:0] lk_ent = lookup_vid[1:0];
	wire lk_in_range = (lookup_vid >= VPM_VID_BASE_MAP2);
	wire lk_present = lk_reg ? map3_present : map2_present;
	wire lk_enable = lookup_from_el1 ? el1_map_enable : el0_map_enable;
	// valid bit, enable and EL2 all required; limitation: no partial mapping
	wire lk_use = lk_in_range && lk_present && el2_enabled
		&& lk_enable && map_entry_valid_bits[lookup_vid];
	wire [REG_W-1:0] lk_word = map_q[lk_reg];
	wire [PID_W-1:0] lk_entry = lk_word[lk_ent*PID_W +: PID_W];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lookup_valid_q <= 1'b0;
			lookup_use_q <= 1'b0;
			lookup_phys_q <= '0;
		end else begin
			lookup_valid_q <= lookup_req;
			lookup_use_q <= lookup_req && lk_use;
			// entry data only when used, avoiding unknown reset contents
			lookup_phys_q <= (lookup_req && lk_use) ? lk_entry : '0;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_el0_undef: assert property (
		acc_hit && cur_el == VPM_EL0 |=> resp_valid_q && resp_undef_q && !resp_trap_q)
		else $error("EL0 access not undefined");
	a_nv_redirect: assert property (
		acc_hit && sel_present && cur_el == VPM_EL1 && nv_mem && hit_map2
		|=> resp_redirect_q && resp_slot_offset_q == 12'h950)
		else $error("nested memory access not redirected to slot");
	a_nv_wr_data: assert property (
		acc_hit && sel_present && cur_el == VPM_EL1 && nv_mem && acc_write
		|=> resp_redirect_write_q && resp_data_q == $past(acc_wdata))
		else $error("redirected write lost its data");
	a_el3_trap_ec: assert property (
		resp_trap_el3_q |-> resp_trap_q && resp_syndrome_q == 6'h18
			&& !$past(core_halted && secure_debug_disabled))
		else $error("EL3 trap with wrong syndrome or blocked");
	a_el2_trap: assert property (
		acc_hit && sel_present && cur_el == VPM_EL1 && !nv_mem && nv_only && !el3_trap_on
		|=> resp_trap_q && !resp_trap_el3_q)
		else $error("EL1 nested access did not trap to EL2");
	a_el1_undef: assert property (
		acc_hit && cur_el == VPM_EL1 && !nv_only |=> resp_undef_q)
		else $error("plain EL1 access not undefined");
	a_el3_readback: assert property (
		acc_hit && sel_present && cur_el == VPM_EL3 && acc_write && hit_map2
		##1 acc_hit && sel_present && cur_el == VPM_EL3 && !acc_write && hit_map2
		|=> resp_data_q == $past(acc_wdata, 2))
		else $error("EL3 read does not return written value");
	a_absent_undef: assert property (
		acc_hit && hit_map3 && highest_map_register_index <= 3'h2 |=> resp_undef_q)
		else $error("absent register not undefined");
	a_no_el2_map: assert property (
		lookup_req && !el2_enabled |=> lookup_valid_q && !lookup_use_q)
		else $error("mapping used without EL2");
	a_valid_gate: assert property (
		lookup_use_q |-> $past(map_entry_valid_bits[lookup_vid]))
		else $error("invalid entry used");
	// EL2 paths: the EL3 trap, its debug block and the direct write
	a_el2_el3_trap: assert property (
		acc_hit && sel_present && cur_el == VPM_EL2 && el3_trap_on && !el3_blocked
		|=> resp_trap_el3_q && resp_syndrome_q == 6'h18)
		else $error("EL2 access did not trap to EL3");
	a_debug_block: assert property (
		acc_hit && sel_present && cur_el == VPM_EL2 && el3_trap_on && el3_blocked
		|=> resp_undef_q && !resp_trap_q)
		else $error("blocked EL3 trap not undefined");
	a_el2_write: assert property (
		acc_hit && sel_present && cur_el == VPM_EL2 && !el3_trap_on && acc_write && hit_map3
		|=> map_q[1] == $past(acc_wdata))
		else $error("EL2 write did not reach register 3");
	a_el3_read_ok: assert property (
		acc_hit && sel_present && cur_el == VPM_EL3 && !acc_write
		|=> resp_valid_q && !resp_undef_q && !resp_trap_q && !resp_redirect_q)
		else $error("EL3 read was checked");
	// register 3 redirect slot sits one word above register 2
	a_map3_slot: assert property (
		acc_hit && sel_present && cur_el == VPM_EL1 && nv_mem && hit_map3
		|=> resp_redirect_q && resp_slot_offset_q == 12'h958)
		else $error("register 3 redirect slot wrong");
	a_foreign_enc: assert property (
		acc_req && !hit_map2 && !hit_map3 |=> !resp_valid_q)
		else $error("foreign encoding answered");
	// lookup: entry position, level enable and the range of ids held here
	a_entry_pos: assert property (
		lookup_req && lk_use && lookup_vid == 4'hD
		|=> lookup_phys_q == $past(map_q[1][31:16]))
		else $error("entry 13 not taken from bits 31:16");
	a_level_enable: assert property (
		lookup_req && lookup_from_el1 && !el1_map_enable |=> !lookup_use_q)
		else $error("EL1 id mapped while disabled");
	a_low_ids: assert property (
		lookup_req && !lookup_vid[3] |=> lookup_valid_q && !lookup_use_q)
		else $error("id below 8 mapped here");

	c_redirect: cover property (resp_redirect_q && resp_redirect_write_q);
	c_trap_el3: cover property (resp_trap_el3_q);
	c_el2_write: cover property (do_write && cur_el == VPM_EL2);
	c_lookup_use: cover property (lookup_use_q);
	c_el3_read: cover property (acc_hit && cur_el == VPM_EL3 && !acc_write);
endmodule // vpm_regs

// ==== rtl/vpm_pkg.sv ====
// vpm_pkg: constants shared by the partition map register block
package vpm_pkg;
	// ==========================================================
	// system register encodings
	localparam logic [1:0] VPM_OP0 = 2'h3;
	localparam logic [2:0] VPM_OP1 = 3'h4;
	localparam logic [3:0] VPM_CRN = 4'hA;
	localparam logic [3:0] VPM_CRM = 4'h6;
	localparam logic [2:0] VPM_OP2_MAP2 = 3'h2; // map register 2
	localparam logic [2:0] VPM_OP2_MAP3 = 3'h3; // map register 3
	// ==========================================================
	// presence thresholds: index field must exceed these
	localparam logic [2:0] VPM_MIN_IDX_MAP2 = 3'h1;
	localparam logic [2:0] VPM_MIN_IDX_MAP3 = 3'h2;
	// ==========================================================
	// redirect slot offsets and trap syndrome
	localparam logic [11:0] VPM_SLOT_MAP2 = 12'h950;
	localparam logic [11:0] VPM_SLOT_MAP3 = 12'h958;
	localparam logic [5:0] VPM_EC_SYSREG = 6'h18;
	// ==========================================================
	// exception levels
	localparam logic [1:0] VPM_EL0 = 2'h0;
	localparam logic [1:0] VPM_EL1 = 2'h1;
	localparam logic [1:0] VPM_EL2 = 2'h2;
	localparam logic [1:0] VPM_EL3 = 2'h3;
	// ==========================================================
	// field layout: four entries per register, first virtual id per register
	localparam int VPM_ENTRIES = 4;
	localparam logic [3:0] VPM_VID_BASE_MAP2 = 4'h8;
	localparam logic [3:0] VPM_VID_BASE_MAP3 = 4'hC;
	// reset value of the response data output
	localparam logic [63:0] VPM_DATA_RST = 64'h0;
	// ==========================================================
	// outcome of one access
	typedef enum logic [2:0] {
		VPM_ACCESS,
		VPM_REDIRECT,
		VPM_TRAP_EL2,
		VPM_TRAP_EL3,
		VPM_UNDEF
	} vpm_outcome_e;
endpackage

// ==== tb/vpm_core_model.sv ====
// vpm_core_model: core side that places register moves and lookups on the block
`timescale 1ns/100ps
module vpm_core_model (
	input wire logic ref_clk,
	output logic [119:0] core_bus
);
	// ==========================================================
	// request bus
	// idle until the first send, so nothing is taken during reset
	initial core_bus = '0;
	// one request per call, changed at a rising edge and held a whole cycle
	task automatic send(input logic [119:0] v);
		@(posedge ref_clk);
		core_bus <= v;
	endtask
endmodule // vpm_core_model

// ==== tb/test_vpm_regs.sv ====
// test_vpm_regs: random register moves and lookups checked against a reference
`timescale 1ns/100ps
module test_vpm_regs;
	import vpm_pkg::*;
	// ==========================================================
	// signals
	logic ref_clk, rst, acc_req, acc_write, el2_enabled, nested_virt_bit;
	logic nested_virt_memory_bit, have_el3, lower_level_trap_bit, core_halted;
	logic secure_debug_disabled, partitioning_feature_present, hypervisor_control_present;
	logic el1_map_enable, el0_map_enable, lookup_req, lookup_from_el1;
	logic [1:0] acc_op0, cur_el;
	logic [2:0] acc_op1, acc_op2, highest_map_register_index;
	logic [3:0] acc_crn, acc_crm, lookup_vid;
	logic [63:0] acc_wdata, resp_data_q;
	logic [15:0] map_entry_valid_bits, lookup_phys_q;
	logic resp_valid_q, resp_undef_q, resp_trap_q, resp_trap_el3_q, resp_redirect_q;
	logic resp_redirect_write_q, lookup_valid_q, lookup_use_q;
	logic [5:0] resp_syndrome_q;
	logic [11:0] resp_slot_offset_q;
	logic [119:0] core_bus, v;
	logic [86:0] acc_q[$]; // expected access answers, oldest first
	logic [16:0] look_q[$]; // expected lookup answers
	logic [63:0] shadow[2]; // reference copy of registers 2 and 3
	int fails, n_compared, seed;
	// the core model drives every input of the block except clock and reset through one bus
	assign {acc_req, acc_write, acc_op0, acc_op1, acc_crn, acc_crm, acc_op2, acc_wdata,
		cur_el, el2_enabled, nested_virt_bit, nested_virt_memory_bit, have_el3,
		lower_level_trap_bit, core_halted, secure_debug_disabled,
		partitioning_feature_present, hypervisor_control_present,
		highest_map_register_index, el1_map_enable, el0_map_enable,
		map_entry_valid_bits, lookup_req, lookup_vid, lookup_from_el1} = core_bus;
	vpm_core_model i_vpm_core_model (.ref_clk(ref_clk), .core_bus(core_bus));
	vpm_regs i_vpm_regs (
		.ref_clk(ref_clk), .rst(rst), .acc_req(acc_req), .acc_write(acc_write),
		.acc_op0(acc_op0), .acc_op1(acc_op1), .acc_crn(acc_crn), .acc_crm(acc_crm),
		.acc_op2(acc_op2), .acc_wdata(acc_wdata), .cur_el(cur_el), .el2_enabled(el2_enabled),
		.nested_virt_bit(nested_virt_bit), .nested_virt_memory_bit(nested_virt_memory_bit),
		.have_el3(have_el3), .lower_level_trap_bit(lower_level_trap_bit),
		.core_halted(core_halted), .secure_debug_disabled(secure_debug_disabled),
		.partitioning_feature_present(partitioning_feature_present),
		.hypervisor_control_present(hypervisor_control_present),
		.highest_map_register_index(highest_map_register_index),
		.el1_map_enable(el1_map_enable), .el0_map_enable(el0_map_enable),
		.map_entry_valid_bits(map_entry_valid_bits), .lookup_req(lookup_req),
		.lookup_vid(lookup_vid), .lookup_from_el1(lookup_from_el1),
		.resp_valid_q(resp_valid_q), .resp_undef_q(resp_undef_q), .resp_trap_q(resp_trap_q),
		.resp_trap_el3_q(resp_trap_el3_q), .resp_syndrome_q(resp_syndrome_q),
		.resp_redirect_q(resp_redirect_q), .resp_redirect_write_q(resp_redirect_write_q),
		.resp_slot_offset_q(resp_slot_offset_q), .resp_data_q(resp_data_q),
		.lookup_valid_q(lookup_valid_q), .lookup_use_q(lookup_use_q),
		.lookup_phys_q(lookup_phys_q)
	);
	// ==========================================================
	// checking
	task automatic check(input string what, input logic [86:0] exp, input logic [86:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// note what the block owes for the request now on the bus
	task automatic predict();
		logic pres, e3p, u, t, t3, rd, dir, e3, r3;
		logic [3:0] id;
		logic [63:0] d;
		id = lookup_vid;
		r3 = acc_op2[0];
		// lookup first: a write in this same cycle is seen only from the next one
		if (lookup_req) begin
			pres = partitioning_feature_present & hypervisor_control_present
				& (highest_map_register_index > (id[2] ? 3'h2 : 3'h1));
			u = id[3] & pres & el2_enabled & map_entry_valid_bits[id]
				& (lookup_from_el1 ? el1_map_enable : el0_map_enable);
			look_q.push_back({u, u ? shadow[id[2]][id[1:0]*16 +: 16] : 16'h0});
		end
		if (acc_req && {acc_op0, acc_op1, acc_crn, acc_crm, acc_op2[2:1]}
			== {VPM_OP0, VPM_OP1, VPM_CRN, VPM_CRM, 2'h1}) begin
			pres = partitioning_feature_present & hypervisor_control_present
				& (highest_map_register_index > (r3 ? 3'h2 : 3'h1));
			e3p = have_el3 & lower_level_trap_bit;
			{u, t, t3, rd, dir, e3} = '0;
			if (!pres || cur_el == VPM_EL0) u = 1;
			else if (cur_el == VPM_EL1) begin
				if (el2_enabled & nested_virt_bit & nested_virt_memory_bit) rd = 1;
				else if (!(el2_enabled & nested_virt_bit)) u = 1;
				else if (!e3p) t = 1;
				else e3 = 1;
			end else if (cur_el == VPM_EL2 && e3p) e3 = 1;
			else dir = 1;
			if (e3) begin
				u = core_halted & secure_debug_disabled;
				t = !u;
				t3 = !u;
			end
			d = (rd & acc_write) ? acc_wdata : ((dir & !acc_write) ? shadow[r3] : 64'h0);
			acc_q.push_back({u, t, t3, t ? VPM_EC_SYSREG : 6'h0, rd, rd & acc_write,
				rd ? (r3 ? VPM_SLOT_MAP3 : VPM_SLOT_MAP2) : 12'h0, d});
			if (dir & acc_write) shadow[r3] = acc_wdata;
		end
	endtask
	// take the oldest note off a queue whenever the block answers; outputs are unknown
	// before the first reset edge, so nothing is looked at while reset is held
	always @(posedge ref_clk) begin
		if (!rst && resp_valid_q !== 1'b0) begin
			if (acc_q.size() == 0) check("spare access answer", 87'h0, 87'h1);
			else check("access answer", acc_q.pop_front(), {resp_undef_q, resp_trap_q,
				resp_trap_el3_q, resp_syndrome_q, resp_redirect_q, resp_redirect_write_q,
				resp_slot_offset_q, resp_data_q});
		end
		if (!rst && lookup_valid_q !== 1'b0) begin
			if (look_q.size() == 0) check("spare lookup", 87'h0, 87'h1);
			else check("lookup", look_q.pop_front(), {lookup_use_q, lookup_phys_q});
		end
	end
	// ==========================================================
	// run control
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	// watchdog: the run needs about 3020 cycles of 4 ns
	initial begin
		#40000;
		fails++;
		stop_test();
	end
	initial begin
		seed = 62;
		fails = 0;
		n_compared = 0;
		rst = 1;
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		// load both registers from EL3 so that later reads have known values
		for (int i = 0; i < 2; i++) begin
			v = {2'h3, VPM_OP0, VPM_OP1, VPM_CRN, VPM_CRM, 2'h1, i[0], $random(seed),
				$random(seed), VPM_EL3, 7'h0, 2'h3, 3'h7, 24'h0};
			i_vpm_core_model.send(v);
			#1 predict();
		end
		$display("load test done");
		// random levels, controls and back-to-back moves, some with foreign encodings
		for (int i = 0; i < 3000; i++) begin
			v = {$random(seed), $random(seed), $random(seed), $random(seed)};
			if (v[3:0] != 4'h0) v[117:103] = {VPM_OP0, VPM_OP1, VPM_CRN, VPM_CRM, 2'h1};
			if (v[7:6] != 2'h0) v[28:27] = 2'h3;
			i_vpm_core_model.send(v);
			#1 predict();
		end
		i_vpm_core_model.send('0);
		repeat (4) @(posedge ref_clk);
		check("answers left", 87'h0, 87'(acc_q.size() + look_q.size()));
		$display("random test done");
		stop_test();
	end
endmodule // test_vpm_regs
